// >>> verilog/iot_pkg.sv
// constants, field layouts and carrier types for the oscillator tuning block
// assumes a 32-bit axi4-lite register bus and a 25 MHz system clock
`default_nettype none
package iot_pkg;
  // bus shape
  localparam int IOT_AXI_AW = 8;
  localparam int IOT_DATA_W = 32;
  // register byte addresses
  localparam logic [IOT_AXI_AW-1:0] IOT_ADDR_TUNE = 8'h00;
  localparam logic [IOT_AXI_AW-1:0] IOT_ADDR_STAT = 8'h04;
  // axi response codes
  localparam logic [1:0] IOT_RESP_OKAY = 2'h0;
  localparam logic [1:0] IOT_RESP_SLVERR = 2'h2;
  // tuning register field positions
  localparam int IOT_SRC_BIT = 7;
  localparam int IOT_PLL_BIT = 6;
  localparam int IOT_TRIM_LSB = 0;
  localparam int IOT_TRIM_W = 5;
  localparam int IOT_TUNE_W = 8;
  // status register field positions
  localparam int IOT_ST_PLL_ON = 0;
  localparam int IOT_ST_ALLOWED = 1;
  localparam int IOT_ST_SRC = 2;
  localparam int IOT_ST_MASTER_CLEAR_PIN = 3;
  localparam int IOT_ST_WORD_LSB = 4;
  // trim codes: two's complement around the calibrated centre
  localparam logic [IOT_TRIM_W-1:0] IOT_TRIM_CENTRE = 5'h00;
  localparam logic [IOT_TRIM_W-1:0] IOT_TRIM_MAX = 5'h0F;
  localparam logic [IOT_TRIM_W-1:0] IOT_TRIM_MIN = 5'h10;
  // slow clock derived from the fast oscillator
  localparam int unsigned IOT_FAST_OSC_HZ = 8000000;
  localparam int unsigned IOT_SLOW_HZ = 31250;
  localparam int unsigned IOT_SLOW_DIV = IOT_FAST_OSC_HZ / IOT_SLOW_HZ;
  // synchroniser reset levels: bit 0 master clear (low active), bit 1 strap
  localparam int IOT_NSYNC = 2;
  localparam logic [IOT_NSYNC-1:0] IOT_SYNC_RST = 2'h1;

  typedef struct packed {
    logic low_freq_source_select;
    logic pll_multiplier_enable;
    logic unused_zero;
    logic [IOT_TRIM_W-1:0] freq_trim_code;
  } iot_tune_t;

  localparam iot_tune_t IOT_TUNE_RST = 8'h00;

  typedef struct packed {
    logic slow_from_fast_osc;
    logic pll_on;
    logic [IOT_TRIM_W-1:0] freq_trim_code;
    logic [IOT_TRIM_W-1:0] osc_ctrl_word;
  } iot_osc_ctrl_t;

  typedef enum logic [1:0] {
    IOT_RATE_OTHER = 2'h0,
    IOT_RATE_4MHZ = 2'h1,
    IOT_RATE_8MHZ = 2'h2
  } iot_rate_t;

  typedef enum logic [1:0] {
    IOT_WR_IDLE = 2'b01,
    IOT_WR_RESP = 2'b10
  } iot_wr_state_t;

  typedef enum logic [1:0] {
    IOT_RD_IDLE = 2'b01,
    IOT_RD_RESP = 2'b10
  } iot_rd_state_t;
endpackage
`default_nettype wire

// >>> verilog/iot_osc_tune.sv
// internal oscillator tuning register with axi4-lite access
// assumes reset-cause pulses come from logic on aclk; pins are asynchronous
// What this block does
// - source select 1 takes slow clock from divided fast osc, 0 from rc osc
// - multiplier enable turns pll on only while fast osc runs 4 or 8 mhz
// - multiplier enable exists only when strapped; otherwise reads zero
// - trim field is a two's complement offset around the centre frequency
// - every reset class loads zero; wake-up from sleep changes nothing
// - lower trim code lowers frequency, higher code raises it
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module iot_osc_tune
  import iot_pkg::*;
#(
  parameter int unsigned SLOW_DIV = IOT_SLOW_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [IOT_AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [IOT_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [IOT_AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [IOT_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic por_bor_reset,
  input wire logic wdt_reset,
  input wire logic reset_instr,
  input wire logic stack_reset,
  input wire logic master_clear_pin_n,
  input wire logic pll_config_strap,
  input wire iot_rate_t fast_osc_rate,
  input wire logic fast_osc_tick,
  input wire logic slow_rc_tick,
  output iot_osc_ctrl_t osc_ctrl,
  output logic slow_clk_tick
);

  localparam int DIV_W = (SLOW_DIV > 1) ? $clog2(SLOW_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  // refuse a divider that cannot produce a slower clock
  if (SLOW_DIV < 2) begin : g_bad_div
    $error("SLOW_DIV must be at least 2");
  end

  // pin synchronisers: three flops, change accepted when stages 2 and 3 agree
  logic [IOT_NSYNC-1:0] pin_in;
  logic [IOT_NSYNC-1:0] sync1;
  logic [IOT_NSYNC-1:0] sync2;
  logic [IOT_NSYNC-1:0] sync3;
  logic [IOT_NSYNC-1:0] filt;
  logic [IOT_NSYNC-1:0] next_filt;

  assign pin_in = {pll_config_strap, master_clear_pin_n};

  for (genvar i = 0; i < IOT_NSYNC; i++) begin : g_sync
    // filter looks only at the second and third stages
    always_comb begin
      next_filt[i] = (sync2[i] == sync3[i]) ? sync2[i] : filt[i];
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1[i] <= IOT_SYNC_RST[i];
        sync2[i] <= IOT_SYNC_RST[i];
        sync3[i] <= IOT_SYNC_RST[i];
        filt[i] <= IOT_SYNC_RST[i];
      end else if (clk_en) begin
        sync1[i] <= pin_in[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        filt[i] <= next_filt[i];
      end
    end
  end

  logic master_clear_pin_active;
  logic pll_allowed;
  logic sys_clear;

  // every reset class clears the tuning register; wake-up is not among them
  assign master_clear_pin_active = ~filt[0];
  assign pll_allowed = filt[1];
  assign sys_clear = por_bor_reset | wdt_reset | reset_instr |
                     stack_reset | master_clear_pin_active;

  // register and bus state
  iot_tune_t tune;
  iot_tune_t next_tune;
  iot_wr_state_t wr_state;
  iot_wr_state_t next_wr_state;
  iot_rd_state_t rd_state;
  iot_rd_state_t next_rd_state;
  logic aw_held;
  logic next_aw_held;
  logic [IOT_AXI_AW-1:0] aw_addr;
  logic [IOT_AXI_AW-1:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [IOT_DATA_W-1:0] w_data;
  logic [IOT_DATA_W-1:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [IOT_DATA_W-1:0] next_rdata;
  logic [IOT_DATA_W-1:0] tune_rd;
  logic [IOT_DATA_W-1:0] stat_rd;

  // read views: unimplemented bits come back as zero
  always_comb begin
    tune_rd = '0;
    tune_rd[IOT_SRC_BIT] = tune.low_freq_source_select;
    tune_rd[IOT_PLL_BIT] = tune.pll_multiplier_enable & pll_allowed;
    tune_rd[IOT_TRIM_LSB +: IOT_TRIM_W] = tune.freq_trim_code;
    stat_rd = '0;
    stat_rd[IOT_ST_PLL_ON] = osc_ctrl.pll_on;
    stat_rd[IOT_ST_ALLOWED] = pll_allowed;
    stat_rd[IOT_ST_SRC] = osc_ctrl.slow_from_fast_osc;
    stat_rd[IOT_ST_MASTER_CLEAR_PIN] = master_clear_pin_active;
    stat_rd[IOT_ST_WORD_LSB +: IOT_TRIM_W] = osc_ctrl.osc_ctrl_word;
  end

  // write channel: address and data taken in either order, then answered
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_tune = tune;
    unique case (wr_state)
      IOT_WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_w_held = 1'b1;
          next_w_data = s_axi_wdata;
          next_w_lane0 = s_axi_wstrb[0];
        end
        if (next_aw_held && next_w_held) begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bvalid = 1'b1;
          next_wr_state = IOT_WR_RESP;
          next_bresp = IOT_RESP_OKAY;
          if (next_aw_addr == IOT_ADDR_TUNE) begin
            if (next_w_lane0) begin
              // new trim lands in the register at this edge
              next_tune.low_freq_source_select =
                next_w_data[IOT_SRC_BIT];
              next_tune.pll_multiplier_enable =
                next_w_data[IOT_PLL_BIT];
              next_tune.freq_trim_code =
                next_w_data[IOT_TRIM_LSB +: IOT_TRIM_W];
            end
          end else if (next_aw_addr != IOT_ADDR_STAT) begin
            next_bresp = IOT_RESP_SLVERR;
          end
        end
      end
      IOT_WR_RESP: begin
        if (s_axi_bready) begin
          next_bvalid = 1'b0;
          next_wr_state = IOT_WR_IDLE;
        end
      end
    endcase
    next_tune.unused_zero = 1'b0;
    // the enable bit cannot hold a one without the strap
    if (!pll_allowed) begin
      next_tune.pll_multiplier_enable = 1'b0;
    end
    if (sys_clear) begin
      next_tune = IOT_TUNE_RST;
    end
    next_awready = (next_wr_state == IOT_WR_IDLE) && !next_aw_held;
    next_wready = (next_wr_state == IOT_WR_IDLE) && !next_w_held;
  end

  // read channel: one read at a time, data one cycle after address
  always_comb begin
    next_rd_state = rd_state;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    unique case (rd_state)
      IOT_RD_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          next_rvalid = 1'b1;
          next_rd_state = IOT_RD_RESP;
          next_rresp = IOT_RESP_OKAY;
          if (s_axi_araddr == IOT_ADDR_TUNE) begin
            next_rdata = tune_rd;
          end else if (s_axi_araddr == IOT_ADDR_STAT) begin
            next_rdata = stat_rd;
          end else begin
            next_rdata = '0;
            next_rresp = IOT_RESP_SLVERR;
          end
        end
      end
      IOT_RD_RESP: begin
        if (s_axi_rready) begin
          next_rvalid = 1'b0;
          next_rd_state = IOT_RD_IDLE;
        end
      end
    endcase
    next_arready = (next_rd_state == IOT_RD_IDLE);
  end

  // bus and register flops; sleep wake-up has no path in here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tune <= IOT_TUNE_RST;
      wr_state <= IOT_WR_IDLE;
      rd_state <= IOT_RD_IDLE;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IOT_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= IOT_RESP_OKAY;
      s_axi_rdata <= '0;
    end else if (clk_en) begin
      tune <= next_tune;
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // oscillator control outputs follow the register one edge later
  iot_osc_ctrl_t next_osc_ctrl;
  logic rate_ok;

  assign rate_ok = (fast_osc_rate == IOT_RATE_4MHZ) ||
                   (fast_osc_rate == IOT_RATE_8MHZ);

  always_comb begin
    next_osc_ctrl.slow_from_fast_osc = tune.low_freq_source_select;
    next_osc_ctrl.pll_on = tune.pll_multiplier_enable & pll_allowed &
                           rate_ok;
    next_osc_ctrl.freq_trim_code = tune.freq_trim_code;
    // flipping the sign bit gives an unsigned word that rises with the code
    next_osc_ctrl.osc_ctrl_word = tune.freq_trim_code ^ IOT_TRIM_MIN;
  end

  // slow clock: divided fast oscillator or the rc oscillator's own ticks
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic div_wrap;
  logic next_slow_tick;

  always_comb begin
    next_div_cnt = div_cnt;
    div_wrap = 1'b0;
    if (fast_osc_tick) begin
      if (div_cnt == DIV_LAST) begin
        next_div_cnt = DIV_ZERO;
        div_wrap = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 1'b1;
      end
    end
    next_slow_tick = tune.low_freq_source_select ? div_wrap :
                     slow_rc_tick;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ctrl <= {1'b0, 1'b0, IOT_TRIM_CENTRE, IOT_TRIM_MIN};
      div_cnt <= DIV_ZERO;
      slow_clk_tick <= 1'b0;
    end else if (clk_en) begin
      osc_ctrl <= next_osc_ctrl;
      div_cnt <= next_div_cnt;
      slow_clk_tick <= next_slow_tick;
    end
  end

endmodule
`default_nettype wire

// >>> verif/iot_osc_tune_monitor.sv
// checker for the oscillator tuning block, watching its ports only
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module iot_osc_tune_monitor
  import iot_pkg::*;
#(
  parameter int unsigned SLOW_DIV = IOT_SLOW_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [IOT_DATA_W-1:0] s_axi_rdata,
  input wire logic por_bor_reset,
  input wire logic wdt_reset,
  input wire logic reset_instr,
  input wire logic stack_reset,
  input wire iot_rate_t fast_osc_rate,
  input wire logic fast_osc_tick,
  input wire logic slow_rc_tick,
  input wire iot_osc_ctrl_t osc_ctrl,
  input wire logic slow_clk_tick
);
  default clocking cb @(posedge aclk);
  endclocking
  // a frozen block answers nothing, so frozen cycles are not judged
  default disable iff (!aresetn || !clk_en);
  // bus answers and holding
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write got no answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read got no answer");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  // oscillator outputs
  a_word_offset: assert property (osc_ctrl.osc_ctrl_word ==
    (osc_ctrl.freq_trim_code ^ 5'h10)) else $error("control word wrong");
  a_pll_rate: assert property (osc_ctrl.pll_on |-> $past(fast_osc_rate)
    inside {IOT_RATE_4MHZ, IOT_RATE_8MHZ}) else $error("pll on at bad rate");
  a_cause_clear: assert property (por_bor_reset || wdt_reset ||
    reset_instr || stack_reset |-> ##2 osc_ctrl.freq_trim_code == 5'h00
    && !osc_ctrl.pll_on) else $error("reset cause left trim");
  a_slow_cause: assert property (slow_clk_tick |->
    $past(fast_osc_tick) || $past(slow_rc_tick)) else $error("stray tick");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pll: cover property (osc_ctrl.pll_on);
  c_slow: cover property (slow_clk_tick && osc_ctrl.slow_from_fast_osc);
endmodule
bind iot_osc_tune iot_osc_tune_monitor #(.SLOW_DIV(SLOW_DIV)) mon_i (
  .aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .por_bor_reset, .wdt_reset, .reset_instr, .stack_reset, .fast_osc_rate,
  .fast_osc_tick, .slow_rc_tick, .osc_ctrl, .slow_clk_tick
);
`default_nettype wire

// >>> verif/iot_osc_tune_tb_top.sv
// self-checking bench for the oscillator tuning block
// assumes the block answers on axi4-lite from a 25 MHz aclk
`timescale 1ns/1ps
`default_nettype none
module iot_osc_tune_tb_top
  import iot_pkg::*;
;
  logic aclk, aresetn, clk_en, pll_config_strap, fast_osc_tick;
  logic [IOT_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [IOT_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, slow_rc_tick, slow_clk_tick;
  logic [4:0] cause;
  wire logic por_bor_reset = cause[0];
  wire logic wdt_reset = cause[1];
  wire logic reset_instr = cause[2];
  wire logic stack_reset = cause[3];
  wire logic master_clear_pin_n = !cause[4];
  iot_rate_t fast_osc_rate;
  iot_osc_ctrl_t osc_ctrl;
  int miscompares, n_checks;

  iot_osc_tune #(.SLOW_DIV(4)) iot_osc_tune_i (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .por_bor_reset, .wdt_reset, .reset_instr,
    .stack_reset, .master_clear_pin_n, .pll_config_strap, .fast_osc_rate,
    .fast_osc_tick, .slow_rc_tick, .osc_ctrl, .slow_clk_tick
  );

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask
  // a used-up wait ends the run
  task automatic hang(input int i);
    if (i >= 64) begin
      miscompares++;
      results();
    end
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    hang(i);
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
    // let an edge pass so the next call never re-raises bready at once
    @(posedge aclk);
  endtask
  // one read, compared with data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    hang(i);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    // let an edge pass so the next call never re-raises rready at once
    @(posedge aclk);
  endtask
  // reset values and an unmapped place
  task automatic t_reset;
    rc(IOT_ADDR_TUNE, 32'h0, IOT_RESP_OKAY);
    rc(IOT_ADDR_STAT, 32'h100, IOT_RESP_OKAY);
    rc(8'h08, 32'h0, IOT_RESP_SLVERR);
  endtask
  // reserved bit, strapped multiplier bit and rate gating
  task automatic t_bits;
    iot_rate_t rt[3] = '{IOT_RATE_4MHZ, IOT_RATE_8MHZ, IOT_RATE_OTHER};
    wr(IOT_ADDR_TUNE, 32'hFFFFFFFF);
    rc(IOT_ADDR_TUNE, 32'h9F, IOT_RESP_OKAY);
    pll_config_strap <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(IOT_ADDR_TUNE, 32'hFF);
    rc(IOT_ADDR_TUNE, 32'hDF, IOT_RESP_OKAY);
    rc(IOT_ADDR_STAT, 32'hF6, IOT_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      fast_osc_rate <= rt[k];
      repeat (3) @(posedge aclk);
      chk("pll_on", {31'h0, k < 2}, {31'h0, osc_ctrl.pll_on});
    end
    fast_osc_rate <= IOT_RATE_4MHZ;
    wr(IOT_ADDR_TUNE, 32'h1F);
    repeat (2) @(posedge aclk);
    chk("pll_off", 32'h0, {31'h0, osc_ctrl.pll_on});
  endtask
  // trim extremes reach the control word one edge on
  task automatic t_trim;
    logic [4:0] c[4] = '{5'h0F, 5'h00, 5'h10, 5'h1F};
    for (int k = 0; k < 4; k++) begin
      wr(IOT_ADDR_TUNE, {27'h0, c[k]});
      @(posedge aclk);
      chk("word", {27'h0, c[k] ^ 5'h10},
        {27'h0, osc_ctrl.osc_ctrl_word});
    end
  endtask
  // clock enable low freezes the register, even against a reset cause
  task automatic t_freeze;
    wr(IOT_ADDR_TUNE, 32'h0A);
    clk_en <= 1'b0;
    cause <= 5'h02;
    repeat (3) @(posedge aclk);
    cause <= 5'h00;
    clk_en <= 1'b1;
    rc(IOT_ADDR_TUNE, 32'h0A, IOT_RESP_OKAY);
  endtask
  // every reset cause clears a loaded register
  task automatic t_causes;
    for (int k = 0; k < 5; k++) begin
      wr(IOT_ADDR_TUNE, 32'h9F);
      cause <= 5'h01 << k;
      repeat (k == 4 ? 6 : 1) @(posedge aclk);
      cause <= 5'h00;
      rc(IOT_ADDR_TUNE, 32'h0, IOT_RESP_OKAY);
    end
  endtask
  // slow tick source: interleaved fast and rc ticks
  task automatic t_slow(input logic [31:0] v, input int e);
    int n;
    n = 0;
    wr(IOT_ADDR_TUNE, v);
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 12; i++) begin
      fast_osc_tick <= (i < 8) && !i[0];
      slow_rc_tick <= (i < 8) && i[0];
      @(posedge aclk);
      if (slow_clk_tick === 1'b1) n++;
    end
    chk("slow_ticks", e, n);
  endtask
  // verdict
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // reset, then the scenarios
  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, cause, pll_config_strap} = '0;
    {fast_osc_tick, slow_rc_tick} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hF;
    fast_osc_rate = IOT_RATE_OTHER;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_bits();
    t_trim();
    t_freeze();
    t_causes();
    t_slow(32'h00, 4);
    t_slow(32'h80, 1);
    results();
  end
endmodule
`default_nettype wire
